// ==== core/lvpm_pkg.sv ====
// constants, field layouts and carrier types for the low-voltage power management registers
//
// Overview of operation
// RULE1 - set warning flag while supply below warning trip
// RULE2 - warning flag sticky until software acknowledges
// RULE3 - acknowledge clears flag only if warning gone
// RULE4 - interrupt request while flag and enable set
// RULE5 - enabled detect event forces a device reset
// RULE6 - detect-in-stop bit keeps detect alive in stop
// RULE7 - detect enable gates detect reset and stop
// RULE8 - bit zero enables the bandgap reference buffer
// RULE9 - detect enables and stop select write once; the detect-in-stop bit here takes every write, not just the first
// RULE10 - detect voltage select once per power-on
// RULE11 - detect select picks trip and warning range
// RULE12 - warning select picks point within range
// RULE13 - partial power-down flag shows deep stop recovery
// RULE14 - acknowledge write clears partial power-down flag
// RULE15 - control bit: zero light stop, one deep
// RULE16 - software writes both registers at initialisation
// RULE17 - unimplemented and acknowledge bits read zero
// RULE18 - power-on clears all; others keep voltage selects

package lvpm_pkg;

  // register byte offsets on the apb bus
  localparam logic [7:0] LVPM_OFS_CTRL_ONE = 8'h00;
  localparam logic [7:0] LVPM_OFS_CTRL_TWO = 8'h04;
  localparam logic [7:0] LVPM_OFS_EVT_STATUS = 8'h08;
  localparam logic [7:0] LVPM_OFS_EVT_MASK = 8'h0C;

  // field positions, first register
  localparam int LVPM_B1_WARN_FLAG = 7;
  localparam int LVPM_B1_WARN_ACK = 6;
  localparam int LVPM_B1_WARN_IRQ_EN = 5;
  localparam int LVPM_B1_DET_RST_EN = 4;
  localparam int LVPM_B1_DET_STOP_EN = 3;
  localparam int LVPM_B1_DET_EN = 2;
  localparam int LVPM_B1_BGAP_EN = 0;

  // field positions, second register
  localparam int LVPM_B2_DET_VSEL = 5;
  localparam int LVPM_B2_WARN_VSEL = 4;
  localparam int LVPM_B2_PPD_FLAG = 3;
  localparam int LVPM_B2_PPD_ACK = 2;
  localparam int LVPM_B2_PPD_CTRL = 0;

  // event status bit positions
  localparam int LVPM_EV_WARN = 0;
  localparam int LVPM_EV_PPD = 1;
  localparam int LVPM_EV_DETECT = 2;
  localparam int LVPM_EV_W = 3;

  // values after reset
  localparam logic [7:0] LVPM_RST_CTRL_ONE = 8'h1C;
  localparam logic [7:0] LVPM_RST_CTRL_TWO = 8'h00;
  localparam logic [LVPM_EV_W-1:0] LVPM_RST_EVT = 3'h0;

  // first register control fields
  typedef struct packed {
    logic warn_irq_en;
    logic detect_reset_en;
    logic detect_in_stop_en;
    logic detect_en;
    logic bandgap_buf_en;
  } lvpm_ctrl_one_t;

  // trip and stop selection driven to the analog side
  typedef struct packed {
    logic detect_trip_sel;
    logic [1:0] warn_trip_sel;
    logic deep_stop_sel;
    logic detect_active;
    logic bandgap_buf_en;
  } lvpm_analog_ctrl_t;

endpackage

// ==== core/lvpm_regs.sv ====
// apb slave holding the low-voltage detect, warning and stop control registers
`timescale 1ns/100ps
`default_nettype none

module lvpm_regs
  import lvpm_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_por_reset,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  output logic o_pready,
  output logic [31:0] o_prdata,
  output logic o_pslverr,
  input wire logic i_supply_below_warn,
  input wire logic i_supply_below_detect,
  input wire logic i_stop_mode,
  input wire logic i_deep_stop_recovered,
  output lvpm_analog_ctrl_t o_analog,
  output logic o_detect_reset_req,
  output logic o_irq
);

  // two eight-bit control words at the first two word offsets,
  // then a word of sticky events and its mask
  // every access answers at once, so the bus never waits
  // comparator levels are asynchronous and pass two flops first
  // most state clears on any reset; the two voltage selects and
  // their lock clear on power-on only, so the detect trip cannot
  // move under a low-voltage reset
  // limitation: a write with the low byte strobe off changes
  // nothing, since every register lives in bits 7:0 of its word
  // limitation: comparator glitches shorter than a clock may be missed

  // register byte offset, the low eight address bits; upper address bits ignored
  function automatic logic [7:0] word_ofs(input logic [ADDR_W-1:0] a);
    word_ofs = 8'(a);
  endfunction

  // comparator outputs are analog and asynchronous: two flops each
  logic [1:0] warn_sync;
  logic [1:0] det_sync;

  // synchronisers for the two comparator levels
  // both flops reset low, so a supply already low after reset shows
  // up two edges later and then sets the warning flag
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      warn_sync <= 2'h0;
      det_sync <= 2'h0;
    end else begin
      warn_sync <= {warn_sync[0], i_supply_below_warn};
      det_sync <= {det_sync[0], i_supply_below_detect};
    end
  end

  logic below_warn; // synchronised warning level
  logic below_detect; // synchronised detect level
  assign below_warn = warn_sync[1];
  assign below_detect = det_sync[1];

  // bus decode, shared by all register groups
  // writes land at the end of the access cycle; reads are sampled
  // one edge earlier, in the setup cycle, so the data is a flop
  logic setup_ph; // first apb cycle
  logic access_wr; // write takes effect here
  logic byte0_wr; // low byte lane written
  logic [7:0] ofs; // decoded offset
  logic [7:0] wbyte; // low write byte
  assign setup_ph = i_psel & ~i_penable;
  assign access_wr = i_psel & i_penable & i_pwrite;
  assign byte0_wr = access_wr & i_pstrb[0];
  assign ofs = word_ofs(i_paddr);
  assign wbyte = i_pwdata[7:0];

  logic wr_one; // write to first register
  logic wr_two; // write to second register
  logic wr_mask; // write to event mask
  assign wr_one = byte0_wr & (ofs == LVPM_OFS_CTRL_ONE);
  assign wr_two = byte0_wr & (ofs == LVPM_OFS_CTRL_TWO);
  assign wr_mask = byte0_wr & (ofs == LVPM_OFS_EVT_MASK);

  // state cleared by any reset
  // one_written and two_written live here, so any reset reopens them
  logic warn_flag;
  lvpm_ctrl_one_t ctrl;
  logic one_written; // write-once lock, first register
  logic two_written; // write-once lock, second register
  logic partial_pd_flag;
  logic partial_pd_ctrl;
  logic [LVPM_EV_W-1:0] evt_status;
  logic [LVPM_EV_W-1:0] evt_mask;
  logic det_prev; // last detect event level

  logic next_warn_flag;
  lvpm_ctrl_one_t next_ctrl;
  logic next_one_written;
  logic next_two_written;
  logic next_partial_pd_flag;
  logic next_partial_pd_ctrl;
  logic [LVPM_EV_W-1:0] next_evt_status;
  logic [LVPM_EV_W-1:0] next_evt_mask;
  logic next_det_prev;

  // state that only power-on clears
  // the detect trip must not move under a low-voltage reset, or the
  // part could keep resetting itself on a changed threshold
  logic detect_volt_sel;
  logic warn_volt_sel;
  logic volt_written; // once per power-on lock
  logic next_detect_volt_sel;
  logic next_warn_volt_sel;
  logic next_volt_written;

  // read capture
  // rd_clr remembers which status bits the reader was shown, so a
  // bit set between setup and access is not lost to the clear
  logic [31:0] rdata;
  logic slverr;
  logic [LVPM_EV_W-1:0] rd_clr; // status bits shown to this read
  logic [31:0] next_rdata;
  logic next_slverr;
  logic [LVPM_EV_W-1:0] next_rd_clr;

  // detect qualified by enable and stop behaviour
  // detect_en gates both the reset request and the stop behaviour
  logic detect_live; // detect logic is running
  logic detect_event; // qualified low-voltage detect
  logic warn_rise; // warning flag just set
  assign detect_live = ctrl.detect_en & (~i_stop_mode | ctrl.detect_in_stop_en); // RULE6 RULE7
  assign detect_event = detect_live & below_detect;

  // warning flag and first register
  // the flag follows the synchronised level: it sets on every cycle
  // the supply is low and only an acknowledge brings it down
  always_comb begin
    next_warn_flag = warn_flag;
    next_ctrl = ctrl;
    next_one_written = one_written;
    // ack only clears once the condition has gone
    if (wr_one && wbyte[LVPM_B1_WARN_ACK] && !below_warn) begin
      next_warn_flag = 1'b0; // RULE3
    end
    // set wins over the ack in the same cycle
    if (below_warn) begin
      next_warn_flag = 1'b1; // RULE1 RULE2
    end
    if (wr_one) begin
      next_ctrl.warn_irq_en = wbyte[LVPM_B1_WARN_IRQ_EN];
      next_ctrl.detect_in_stop_en = wbyte[LVPM_B1_DET_STOP_EN];
      next_ctrl.bandgap_buf_en = wbyte[LVPM_B1_BGAP_EN]; // RULE8
      next_one_written = 1'b1;
      // write-once fields take the first write only
      if (!one_written) begin
        next_ctrl.detect_reset_en = wbyte[LVPM_B1_DET_RST_EN]; // RULE9
        next_ctrl.detect_en = wbyte[LVPM_B1_DET_EN]; // RULE9
      end
    end
  end

  // second register, reset by any reset
  // the recovery pulse comes from the stop sequencer on this clock,
  // so it needs no synchroniser
  always_comb begin
    next_partial_pd_flag = partial_pd_flag;
    next_partial_pd_ctrl = partial_pd_ctrl;
    next_two_written = two_written;
    if (wr_two && wbyte[LVPM_B2_PPD_ACK]) begin
      next_partial_pd_flag = 1'b0; // RULE14
    end
    // recovery in the ack cycle is not lost
    if (i_deep_stop_recovered) begin
      next_partial_pd_flag = 1'b1; // RULE13
    end
    if (wr_two) begin
      next_two_written = 1'b1;
      if (!two_written) begin
        next_partial_pd_ctrl = wbyte[LVPM_B2_PPD_CTRL]; // RULE9 RULE15
      end
    end
  end

  // voltage selects survive non power-on resets
  // warn_volt_sel stays writable; only the detect select is locked
  always_comb begin
    next_detect_volt_sel = detect_volt_sel;
    next_warn_volt_sel = warn_volt_sel;
    next_volt_written = volt_written;
    if (wr_two) begin
      next_warn_volt_sel = wbyte[LVPM_B2_WARN_VSEL]; // RULE12
      next_volt_written = 1'b1;
      if (!volt_written) begin
        next_detect_volt_sel = wbyte[LVPM_B2_DET_VSEL]; // RULE10
      end
    end
  end

  // sticky events, cleared by reading the status register
  // detect is edge-detected so a long brown-out counts once;
  // det_prev resets low, the idle level of the qualified detect
  always_comb begin
    next_det_prev = detect_event;
    next_evt_mask = evt_mask;
    if (wr_mask) begin
      next_evt_mask = wbyte[LVPM_EV_W-1:0];
    end
    // only bits returned to the reader are cleared
    next_evt_status = evt_status;
    if (i_psel && i_penable && !i_pwrite && ofs == LVPM_OFS_EVT_STATUS) begin
      next_evt_status = evt_status & ~rd_clr;
    end
    // set beats the read-clear
    if (warn_rise) begin
      next_evt_status[LVPM_EV_WARN] = 1'b1;
    end
    if (i_deep_stop_recovered) begin
      next_evt_status[LVPM_EV_PPD] = 1'b1;
    end
    if (detect_event && !det_prev) begin
      next_evt_status[LVPM_EV_DETECT] = 1'b1;
    end
  end
  assign warn_rise = next_warn_flag & ~warn_flag;

  // read data taken in the setup cycle so the bus sees a flop
  // trade-off: no wait states, but the value shown is the one
  // present at the setup edge
  always_comb begin
    next_rdata = rdata;
    next_slverr = 1'b0;
    next_rd_clr = rd_clr;
    if (setup_ph) begin
      next_rdata = 32'h0000_0000; // RULE17
      next_rd_clr = '0;
      if (ofs == LVPM_OFS_CTRL_ONE) begin
        next_rdata[LVPM_B1_WARN_FLAG] = warn_flag;
        next_rdata[LVPM_B1_WARN_IRQ_EN] = ctrl.warn_irq_en;
        next_rdata[LVPM_B1_DET_RST_EN] = ctrl.detect_reset_en;
        next_rdata[LVPM_B1_DET_STOP_EN] = ctrl.detect_in_stop_en;
        next_rdata[LVPM_B1_DET_EN] = ctrl.detect_en;
        next_rdata[LVPM_B1_BGAP_EN] = ctrl.bandgap_buf_en;
      end else if (ofs == LVPM_OFS_CTRL_TWO) begin
        next_rdata[LVPM_B2_DET_VSEL] = detect_volt_sel;
        next_rdata[LVPM_B2_WARN_VSEL] = warn_volt_sel;
        next_rdata[LVPM_B2_PPD_FLAG] = partial_pd_flag;
        next_rdata[LVPM_B2_PPD_CTRL] = partial_pd_ctrl;
      end else if (ofs == LVPM_OFS_EVT_STATUS) begin
        next_rdata[LVPM_EV_W-1:0] = evt_status;
        next_rd_clr = i_pwrite ? '0 : evt_status;
      end else if (ofs == LVPM_OFS_EVT_MASK) begin
        next_rdata[LVPM_EV_W-1:0] = evt_mask;
      end else begin
        // unmapped word: error answer, data zero
        next_slverr = 1'b1;
      end
    end else if (i_psel) begin
      next_slverr = slverr; // hold through the access phase
    end
  end

  // registers under any reset
  // reset values are constants only; nothing here reads other state
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      warn_flag <= 1'b0;
      ctrl <= '{warn_irq_en: LVPM_RST_CTRL_ONE[LVPM_B1_WARN_IRQ_EN],
                detect_reset_en: LVPM_RST_CTRL_ONE[LVPM_B1_DET_RST_EN],
                detect_in_stop_en: LVPM_RST_CTRL_ONE[LVPM_B1_DET_STOP_EN],
                detect_en: LVPM_RST_CTRL_ONE[LVPM_B1_DET_EN],
                bandgap_buf_en: LVPM_RST_CTRL_ONE[LVPM_B1_BGAP_EN]};
      one_written <= 1'b0;
      two_written <= 1'b0;
      partial_pd_flag <= LVPM_RST_CTRL_TWO[LVPM_B2_PPD_FLAG]; // RULE18
      partial_pd_ctrl <= LVPM_RST_CTRL_TWO[LVPM_B2_PPD_CTRL];
      evt_status <= LVPM_RST_EVT;
      evt_mask <= LVPM_RST_EVT;
      det_prev <= 1'b0;
      rdata <= 32'h0000_0000;
      slverr <= 1'b0;
      rd_clr <= LVPM_RST_EVT;
    end else begin
      warn_flag <= next_warn_flag;
      ctrl <= next_ctrl;
      one_written <= next_one_written;
      two_written <= next_two_written;
      partial_pd_flag <= next_partial_pd_flag;
      partial_pd_ctrl <= next_partial_pd_ctrl;
      evt_status <= next_evt_status;
      evt_mask <= next_evt_mask;
      det_prev <= next_det_prev;
      rdata <= next_rdata;
      slverr <= next_slverr;
      rd_clr <= next_rd_clr;
    end
  end

  // voltage selects reset by power-on only
  // power-on always comes with the general reset, never alone
  always_ff @(posedge i_clk or posedge i_por_reset) begin
    if (i_por_reset) begin
      detect_volt_sel <= LVPM_RST_CTRL_TWO[LVPM_B2_DET_VSEL]; // RULE18
      warn_volt_sel <= LVPM_RST_CTRL_TWO[LVPM_B2_WARN_VSEL];
      volt_written <= 1'b0;
    end else begin
      detect_volt_sel <= next_detect_volt_sel;
      warn_volt_sel <= next_warn_volt_sel;
      volt_written <= next_volt_written;
    end
  end

  // zero wait states: every access answers in its first access cycle
  // error is gated by the access phase so it never shows in setup
  assign o_pready = 1'b1;
  assign o_prdata = rdata;
  assign o_pslverr = slverr & i_psel & i_penable;

  // analog side controls; one driver for the whole carrier, since
  // separate member assigns would give the port several drivers
  assign o_analog = '{detect_trip_sel: detect_volt_sel, // RULE11
    warn_trip_sel: {detect_volt_sel, warn_volt_sel}, // RULE11 RULE12
    deep_stop_sel: partial_pd_ctrl, // RULE15
    detect_active: detect_live, // RULE6 RULE7
    bandgap_buf_en: ctrl.bandgap_buf_en}; // RULE8

  // reset request is a level: held while the qualified detect lasts
  // the system reset logic applies it; after that reset detect_en
  // returns to one, so the request comes back while the supply is low
  assign o_detect_reset_req = detect_event & ctrl.detect_reset_en; // RULE5 RULE7

  // warning request plus masked sticky events
  // the warning part is a level on the flag, so software must
  // acknowledge the flag as well as read the event word
  assign o_irq = (warn_flag & ctrl.warn_irq_en) | (|(evt_status & evt_mask)); // RULE4

endmodule

`default_nettype wire

// ==== testbench/lvpm_properties.sv ====
// port-level checker for the low-voltage power management register block
`timescale 1ns/100ps
`default_nettype none

module lvpm_properties
  import lvpm_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_por_reset,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  input wire logic o_pready,
  input wire logic [31:0] o_prdata,
  input wire logic o_pslverr,
  input wire logic i_supply_below_warn,
  input wire logic i_supply_below_detect,
  input wire logic i_stop_mode,
  input wire logic i_deep_stop_recovered,
  input wire lvpm_analog_ctrl_t o_analog,
  input wire logic o_detect_reset_req,
  input wire logic o_irq
);
  logic wr_one, wr_two, rd0, mapped; // decoded bus cycles
  logic wr2_seen, dv_seen; // first write to second register seen
  logic [2:0] since_rst; // saturating age since reset, masks sync startup
  assign wr_one = i_psel && i_penable && i_pwrite && i_pstrb[0];
  assign wr_two = wr_one && i_paddr == ADDR_W'(LVPM_OFS_CTRL_TWO);
  assign rd0 = i_psel && i_penable && !i_pwrite && i_paddr == ADDR_W'(LVPM_OFS_CTRL_ONE);
  assign mapped = i_paddr inside {ADDR_W'(LVPM_OFS_CTRL_ONE), ADDR_W'(LVPM_OFS_CTRL_TWO),
    ADDR_W'(LVPM_OFS_EVT_STATUS), ADDR_W'(LVPM_OFS_EVT_MASK)};
  // lock tracking, cleared by any reset
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      wr2_seen <= 1'h0;
      since_rst <= 3'h0;
    end else begin
      wr2_seen <= wr2_seen | wr_two;
      since_rst <= (since_rst == 3'h7) ? since_rst : since_rst + 3'h1;
    end
  end
  // voltage select lock survives all but power-on
  always_ff @(posedge i_clk or posedge i_por_reset) begin
    if (i_por_reset) begin
      dv_seen <= 1'h0;
    end else begin
      dv_seen <= dv_seen | wr_two;
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  AST_SLVERR: assert property (i_psel && i_penable && !mapped |-> o_pslverr && o_prdata == 32'h0)
    else $error("unmapped access not refused");
  AST_RD_UPPER: assert property (i_psel && i_penable && !i_pwrite |-> o_prdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  AST_RD_ACK: assert property (rd0 |-> !o_prdata[6] && !o_prdata[1])
    else $error("ack or reserved bit reads one");
  AST_TRIP_PAIR: assert property (o_analog.warn_trip_sel[1] == o_analog.detect_trip_sel)
    else $error("warning range differs from detect select");
  AST_RST_REQ: assert property (o_detect_reset_req |-> o_analog.detect_active && $past(i_supply_below_detect, 2))
    else $error("reset request without qualified detect");
  AST_DS_ONCE: assert property (wr_two && wr2_seen |=> $stable(o_analog.deep_stop_sel))
    else $error("stop select rewritten");
  AST_DS_FIRST: assert property (wr_two && !wr2_seen |=> o_analog.deep_stop_sel == $past(i_pwdata[0]))
    else $error("first stop select write lost");
  AST_DV_ONCE: assert property (wr_two && dv_seen |=> $stable(o_analog.detect_trip_sel))
    else $error("detect select rewritten");
  AST_BGAP: assert property (wr_one && i_paddr == ADDR_W'(LVPM_OFS_CTRL_ONE) |=> o_analog.bandgap_buf_en == $past(i_pwdata[0]))
    else $error("bandgap enable not written");
  AST_WARN_SEL: assert property (wr_two |=> o_analog.warn_trip_sel[0] == $past(i_pwdata[4]))
    else $error("warning select not written");
  AST_IRQ: assert property (rd0 && o_prdata[7] && o_prdata[5] |-> o_irq)
    else $error("enabled warning without interrupt");
  AST_WARN_SET: assert property (rd0 && since_rst == 3'h7 && $past(i_supply_below_warn, 4) |-> o_prdata[7])
    else $error("warning flag not set");
  cover property (wr_two && wr2_seen);
  cover property (o_detect_reset_req);
  cover property (rd0 && o_prdata[7]);
endmodule

`default_nettype wire

// ==== testbench/testbench.sv ====
// self-checking bench for the low-voltage power management registers
`timescale 1ns/100ps
`default_nettype none

module testbench;
  import lvpm_pkg::*;
  logic i_clk = 1'h0, i_reset = 1'h1, i_por_reset = 1'h1; // held in reset at start
  logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0, sw = 1'h0, sd = 1'h0, stp = 1'h0, dsr = 1'h0;
  logic [7:0] paddr = 8'h00, r, q, e0, e2;
  logic [31:0] pwdata = 32'h0, rd, seed = 32'h1;
  logic [3:0] pstrb = 4'hF; // byte strobes, low lane dropped once
  logic o_pready, o_pslverr, o_irq, o_req;
  logic [31:0] o_prdata;
  lvpm_analog_ctrl_t o_an;
  int fails = 0, checked = 0, cyc = 0;
  always #5 i_clk = ~i_clk;
  lvpm_regs dut (.i_clk(i_clk), .i_reset(i_reset), .i_por_reset(i_por_reset), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb),
    .o_pready(o_pready), .o_prdata(o_prdata), .o_pslverr(o_pslverr), .i_supply_below_warn(sw),
    .i_supply_below_detect(sd), .i_stop_mode(stp), .i_deep_stop_recovered(dsr), .o_analog(o_an),
    .o_detect_reset_req(o_req), .o_irq(o_irq));
  // xorshift source, fixed seed
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic exp_err(input logic [7:0] a);
    return !(a inside {LVPM_OFS_CTRL_ONE, LVPM_OFS_CTRL_TWO, LVPM_OFS_EVT_STATUS, LVPM_OFS_EVT_MASK});
  endfunction
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", n, e, g);
      fails++;
    end
  endtask
  // one apb transfer; waits on pready, global timeout cuts a hang
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge i_clk);
    penable <= 1'h1;
    @(posedge i_clk);
    while (o_pready !== 1'h1) @(posedge i_clk);
    rd = o_prdata;
    chk("slave error", {31'h0, exp_err(a)}, {31'h0, o_pslverr});
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic rdchk(input string n, input logic [7:0] a, input logic [7:0] e);
    apb(1'h0, a, 8'h00);
    chk(n, {24'h0, e}, rd);
  endtask
  task automatic rst(input logic por);
    @(posedge i_clk);
    i_reset <= 1'h1;
    i_por_reset <= por;
    repeat (4) @(posedge i_clk);
    i_reset <= 1'h0;
    i_por_reset <= 1'h0;
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // cycle ceiling, about 150 cycles expected
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      report_and_stop();
    end
  end
  initial begin
    repeat (4) @(posedge i_clk);
    i_reset <= 1'h0;
    i_por_reset <= 1'h0;
    rdchk("one reset", 8'h00, LVPM_RST_CTRL_ONE);
    rdchk("two reset", 8'h04, LVPM_RST_CTRL_TWO);
    for (int i = 0; i < 8; i++) begin
      r = 8'(rnd());
      apb(1'h0, r, 8'h00);
    end
    $display("test reset and map done");
    r = 8'(rnd());
    apb(1'h1, 8'h00, r);
    apb(1'h1, 8'h00, ~r);
    e0 = (r & 8'h14) | (~r & 8'h29);
    rdchk("one once", 8'h00, e0);
    chk("bandgap", {31'h0, ~r[0]}, {31'h0, o_an.bandgap_buf_en});
    q = 8'(rnd());
    apb(1'h1, 8'h04, q);
    apb(1'h1, 8'h04, ~q);
    e2 = (q & 8'h21) | (~q & 8'h10);
    rdchk("two once", 8'h04, e2);
    chk("trip sel", {30'h0, e2[5:4]}, {30'h0, o_an.warn_trip_sel});
    rst(1'h0);
    rdchk("two kept", 8'h04, e2 & 8'h30);
    apb(1'h1, 8'h04, ~q);
    e2 = (q & 8'h20) | (~q & 8'h11);
    rdchk("two relock", 8'h04, e2);
    chk("stop sel", {31'h0, ~q[0]}, {31'h0, o_an.deep_stop_sel});
    $display("test write once done");
    sw <= 1'h1;
    repeat (6) @(posedge i_clk);
    apb(1'h1, 8'h00, 8'h74);
    rdchk("flag held", 8'h00, 8'hB4);
    chk("warn irq", 32'h1, {31'h0, o_irq});
    sw <= 1'h0;
    repeat (6) @(posedge i_clk);
    rdchk("flag sticky", 8'h00, 8'hB4);
    apb(1'h1, 8'h00, 8'h54);
    rdchk("flag clear", 8'h00, 8'h14);
    rdchk("warn event", 8'h08, 8'h01);
    rdchk("event clear", 8'h08, 8'h00);
    apb(1'h1, 8'h0C, 8'h02);
    pstrb <= 4'hE;
    apb(1'h1, 8'h0C, 8'h07);
    pstrb <= 4'hF;
    rdchk("mask strobe", 8'h0C, 8'h02);
    dsr <= 1'h1;
    @(posedge i_clk);
    dsr <= 1'h0;
    repeat (2) @(posedge i_clk);
    chk("event irq", 32'h1, {31'h0, o_irq});
    rdchk("pd flag", 8'h04, e2 | 8'h08);
    rdchk("pd event", 8'h08, 8'h02);
    @(posedge i_clk);
    chk("irq clear", 32'h0, {31'h0, o_irq});
    apb(1'h1, 8'h04, e2 | 8'h04);
    rdchk("pd ack", 8'h04, e2);
    $display("test flags done");
    sd <= 1'h1;
    repeat (4) @(posedge i_clk);
    chk("detect reset", 32'h1, {31'h0, o_req});
    stp <= 1'h1;
    @(posedge i_clk);
    chk("stop gated", 32'h0, {31'h0, o_req});
    chk("detect live", 32'h0, {31'h0, o_an.detect_active});
    apb(1'h1, 8'h00, 8'h08);
    @(posedge i_clk);
    chk("stop kept", 32'h1, {31'h0, o_req});
    stp <= 1'h0;
    rst(1'h1);
    rdchk("two por", 8'h04, 8'h00);
    apb(1'h1, 8'h00, 8'h10);
    repeat (3) @(posedge i_clk);
    chk("detect off", 32'h0, {31'h0, o_req});
    chk("detect idle", 32'h0, {31'h0, o_an.detect_active});
    $display("test detect done");
    report_and_stop();
  end
endmodule

bind lvpm_regs lvpm_properties #(.ADDR_W(ADDR_W)) u_props (.i_clk(i_clk), .i_reset(i_reset),
  .i_por_reset(i_por_reset), .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
  .i_paddr(i_paddr), .i_pwdata(i_pwdata), .i_pstrb(i_pstrb), .o_pready(o_pready),
  .o_prdata(o_prdata), .o_pslverr(o_pslverr), .i_supply_below_warn(i_supply_below_warn),
  .i_supply_below_detect(i_supply_below_detect), .i_stop_mode(i_stop_mode),
  .i_deep_stop_recovered(i_deep_stop_recovered), .o_analog(o_analog),
  .o_detect_reset_req(o_detect_reset_req), .o_irq(o_irq));

`default_nettype wire
